/* File: pkg/trig_seq_pkg.sv */
// shared types and constants of the measurement trigger sequencer
// assumes one 25 MHz clock and a decoded command stream from the bus side
package trig_seq_pkg;

  // ===========================================================
  // trigger source selection
  localparam logic [2:0] src_immediate_source       = 3'h0;
  localparam logic [2:0] src_bus                    = 3'h1;
  localparam logic [2:0] src_hold                   = 3'h2;
  localparam logic [2:0] src_front_connector_source = 3'h3;
  localparam logic [2:0] src_ttl                    = 3'h4;

  // ===========================================================
  // decoded commands
  localparam logic [2:0] cmd_none     = 3'h0;
  localparam logic [2:0] cmd_init     = 3'h1;
  localparam logic [2:0] cmd_trig_now = 3'h2;
  localparam logic [2:0] cmd_bus_trig = 3'h3;
  localparam logic [2:0] cmd_query    = 3'h4;
  localparam logic [2:0] cmd_abort    = 3'h5;

  // ===========================================================
  // error codes, two's complement, 16 bits
  localparam logic [15:0] err_none            = 16'h0000;
  localparam logic [15:0] err_trigger_ignored = 16'hff2d; // -211
  localparam logic [15:0] err_init_ignored    = 16'hff2b; // -213
  localparam logic [15:0] err_trig_deadlock   = 16'hff2a; // -214

  // ===========================================================
  // widths and reset values
  localparam int          count_width  = 16;
  localparam int          ttl_width    = 8;
  localparam logic [15:0] count_reset  = 16'h0001;
  localparam logic [2:0]  ttl_sel_rst  = 3'h0;

  // ===========================================================
  // command word from the bus side
  typedef struct packed {
    logic       valid;   // one-cycle command strobe
    logic [2:0] op;      // decoded command
  } cmd_type;

  // error report to the status logic
  typedef struct packed {
    logic        valid;  // one-cycle error strobe
    logic [15:0] code;   // error code
  } err_type;

endpackage

/* File: rtl/measurement_trigger_sequencer.sv */
// trigger sequencing of a bus controlled multimeter
// assumes decoded commands, a measurement engine with start and done,
// and trigger pulses arriving asynchronously on pins
`timescale 1ns/10ps

// How it works
// - trigger now unarmed gives trigger ignored
// - immediate source init takes one reading
// - trigger now in immediate source errors
// - immediate query takes count readings back
// - pulse source query answers after count pulses
// - waiting query holds the command bus
// - wait ends on last reading or clear
// - one reading per matching trigger when armed
// - front connector and backplane lines trigger
// - completion pulses drive only the backplane
module measurement_trigger_sequencer #(
  parameter int cnt_w = trig_seq_pkg::count_width, // trigger count width
  parameter int ttl_w = trig_seq_pkg::ttl_width    // backplane line count
) (
  input  wire logic                  clk,         // 25 MHz clock
  input  wire logic                  rst_n,       // sync reset, low
  input  wire logic                  dev_clear,   // device clear pulse
  input  wire trig_seq_pkg::cmd_type cmd,         // decoded command
  input  wire logic [2:0]            src_sel,     // trigger source
  input  wire logic [2:0]            ttl_sel,     // chosen backplane line
  input  wire logic [cnt_w-1:0]      trig_count,  // readings per block
  input  wire logic                  front_trig,  // front connector pin
  input  wire logic [ttl_w-1:0]      ttl_in,      // backplane lines in
  input  wire logic                  meas_done,   // engine finished
  output logic                       meas_start,  // start one reading
  output logic                       meas_store,  // store, not return
  output logic                       result_rdy,  // query answer ready
  output logic                       bus_hold,    // refuse commands
  output logic                       cmd_ready,   // commands accepted
  output trig_seq_pkg::err_type      err,         // error report
  output logic                       armed,       // waiting for trigger
  output logic [ttl_w-1:0]           ttl_out,     // backplane drive
  output logic [ttl_w-1:0]           ttl_oe       // backplane enable
);

  // ===========================================================
  // state machine
  typedef enum logic [4:0] {
    st_idle  = 5'b00001,  // not armed
    st_armed = 5'b00010,  // waiting for trigger, commands accepted
    st_meas  = 5'b00100,  // reading under way, store it
    st_qwait = 5'b01000,  // query holding bus for pulses
    st_qmeas = 5'b10000   // query reading under way
  } state_type;

  state_type      state_q, state_d;    // sequencer state
  logic [cnt_w-1:0] left_q, left_d;    // readings still owed
  logic           busy_q, busy_d;      // engine started, not done
  logic           store_q;             // store flag of the last start
  logic           hold_q;              // registered bus hold
  trig_seq_pkg::err_type err_q, err_d; // registered error
  logic [ttl_w-1:0] ttl_q;             // completion pulse drive

  // ===========================================================
  // pin synchronisers
  logic             front_rise;        // front connector edge
  logic [ttl_w-1:0] ttl_rise;          // backplane edges

  // front connector pulses are an accepted source
  pulse_sync u_front (
    .clk   (clk),
    .rst_n (rst_n),
    .level (front_trig),
    .rise  (front_rise)
  );

  // every backplane line is synchronised, one is chosen below
  genvar gi;
  generate
    for (gi = 0; gi < ttl_w; gi++) begin : g_ttl
      pulse_sync u_ttl (
        .clk   (clk),
        .rst_n (rst_n),
        .level (ttl_in[gi]),
        .rise  (ttl_rise[gi])
      );
    end
  endgenerate

  // ===========================================================
  // decode
  // true when the chosen source is a pulse input
  function automatic logic is_pulse_src(input logic [2:0] s);
    is_pulse_src = (s == trig_seq_pkg::src_front_connector_source) ||
                   (s == trig_seq_pkg::src_ttl);
  endfunction

  // error strobe builder
  function automatic trig_seq_pkg::err_type mk_err(input logic [15:0] c);
    mk_err.valid = 1'b1;
    mk_err.code  = c;
  endfunction

  wire cmd_v      = cmd.valid && !hold_q;      // held bus drops commands
  wire is_init    = cmd_v && cmd.op == trig_seq_pkg::cmd_init;
  wire is_trignow = cmd_v && cmd.op == trig_seq_pkg::cmd_trig_now;
  wire is_bustrig = cmd_v && cmd.op == trig_seq_pkg::cmd_bus_trig;
  wire is_query   = cmd_v && cmd.op == trig_seq_pkg::cmd_query;
  wire is_abort   = cmd_v && cmd.op == trig_seq_pkg::cmd_abort;
  wire src_imm    = src_sel == trig_seq_pkg::src_immediate_source;
  wire src_bus    = src_sel == trig_seq_pkg::src_bus;
  wire src_hold   = src_sel == trig_seq_pkg::src_hold;
  wire src_front  = src_sel == trig_seq_pkg::src_front_connector_source;
  wire src_ttl    = src_sel == trig_seq_pkg::src_ttl;
  wire ttl_hit    = ttl_rise[ttl_sel];
  // only the pulse of the selected source counts, others ignored
  wire pulse_hit  = (src_front && front_rise) ||
                    (src_ttl && ttl_hit);
  wire count_zero = trig_count == '0;
  wire [cnt_w-1:0] count_eff = count_zero ?
                    cnt_w'(trig_seq_pkg::count_reset) : trig_count;

  // ===========================================================
  // next state
  always_comb begin
    state_d    = state_q;
    left_d     = left_q;
    busy_d     = busy_q;
    err_d      = '0;
    meas_start = 1'b0;
    meas_store = store_q;
    result_rdy = 1'b0;
    if (busy_q && meas_done) begin
      busy_d = 1'b0;
    end
    case (state_q)
      st_idle: begin
        if (is_init && src_imm) begin
          // immediate init: one stored reading, then idle
          meas_start = 1'b1;
          meas_store = 1'b1;
          busy_d     = 1'b1;
          state_d    = st_meas;
        end else if (is_init) begin
          state_d = st_armed;
        end else if (is_trignow || is_bustrig) begin
          // unarmed, also always in immediate source
          err_d = mk_err(trig_seq_pkg::err_trigger_ignored);
        end else if (is_query && src_bus) begin
          err_d = mk_err(trig_seq_pkg::err_trig_deadlock);
        end else if (is_query && src_hold) begin
          err_d = mk_err(trig_seq_pkg::err_init_ignored);
        end else if (is_query && src_imm) begin
          // block of back to back readings
          left_d     = count_eff;
          meas_start = 1'b1;
          meas_store = 1'b0;
          busy_d     = 1'b1;
          state_d    = st_qmeas;
        end else if (is_query) begin
          left_d  = count_eff;
          state_d = st_qwait;
        end
      end
      st_armed: begin
        if (is_abort) begin
          state_d = st_idle;
        end else if (is_trignow || (is_bustrig && src_bus) ||
                     pulse_hit) begin
          // one reading per matching trigger
          meas_start = 1'b1;
          meas_store = 1'b1;
          busy_d     = 1'b1;
          state_d    = st_meas;
        end else if (is_bustrig) begin
          err_d = mk_err(trig_seq_pkg::err_trigger_ignored);
        end
      end
      st_meas: begin
        if (busy_q && meas_done) begin
          // immediate source drops back to idle, others rearm
          state_d = src_imm ? st_idle : st_armed;
        end
      end
      st_qwait: begin
        if (pulse_hit) begin
          meas_start = 1'b1;
          meas_store = 1'b0;
          busy_d     = 1'b1;
          state_d    = st_qmeas;
        end
      end
      st_qmeas: begin
        if (busy_q && meas_done) begin
          left_d = left_q - cnt_w'(1);
          if (left_q == cnt_w'(1)) begin
            result_rdy = 1'b1;
            state_d    = st_idle;
          end else if (is_pulse_src(src_sel)) begin
            state_d = st_qwait;
          end else begin
            meas_start = 1'b1;
            busy_d     = 1'b1;
          end
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
    if (dev_clear) begin
      // device clear abandons any wait
      state_d    = st_idle;
      meas_start = 1'b0;
      result_rdy = 1'b0;
      busy_d     = 1'b0;
    end
  end

  // ===========================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= st_idle;
      left_q  <= '0;
      busy_q  <= 1'b0;
      store_q <= 1'b0;
      err_q   <= '0;
    end else begin
      state_q <= state_d;
      left_q  <= left_d;
      busy_q  <= busy_d;
      store_q <= meas_store;
      err_q   <= err_d;
    end
  end

  // bus held while a query waits on pulses or readings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= (state_d == st_qwait) || (state_d == st_qmeas);
    end
  end

  // completion pulse only onto the chosen backplane line
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ttl_q <= '0;
    end else begin
      ttl_q <= (busy_q && meas_done) ?
               (ttl_w'(1) << ttl_sel) : '0;
    end
  end

  // ===========================================================
  // outputs from flops; meas_start, meas_store and result_rdy are
  // left combinational on purpose, so that the engine starts in the
  // cycle of the trigger and the answer meets the last meas_done
  assign err       = err_q;
  assign bus_hold  = hold_q;
  assign cmd_ready = ~hold_q;
  assign armed     = state_q == st_armed;
  assign ttl_out   = ttl_q;
  assign ttl_oe    = ttl_q;

endmodule

/* File: rtl/pulse_sync.sv */
// two-flop synchroniser with rising edge pulse
// assumes an asynchronous level input and one clock
`timescale 1ns/10ps

module pulse_sync (
  input  wire logic clk,     // module clock
  input  wire logic rst_n,   // synchronous reset, active low
  input  wire logic level,   // asynchronous input level
  output logic      rise     // one-cycle pulse on a rising edge
);

  // ===========================================================
  // synchroniser and edge detector
  logic meta_q;    // first stage, read only by sync_q
  logic sync_q;    // second stage
  logic last_q;    // delayed copy for the edge

  // sample the pin through two flops, then one more for the edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= level;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // rising edge of the synchronised level
  assign rise = sync_q & ~last_q;

endmodule

/* File: test/commander_model.sv */
// bus commander model: command strobes and device clear
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/10ps
module commander_model (
  input  wire logic             clk,       // module clock
  output trig_seq_pkg::cmd_type cmd,       // command strobe
  output logic                  dev_clear  // device clear pulse
);
  initial begin
    cmd = '0;
    dev_clear = 1'b0;
  end
  // one-cycle command strobe, launched on an edge
  task automatic send(input logic [2:0] op);
    @(posedge clk);
    cmd <= '{valid: 1'b1, op: op};
    @(posedge clk);
    cmd <= '0;
  endtask
  // the only way to abandon a held query early
  task automatic clear();
    @(posedge clk);
    dev_clear <= 1'b1;
    @(posedge clk);
    dev_clear <= 1'b0;
  endtask
endmodule

/* File: test/measurement_trigger_sequencer_tb_top.sv */
// self-checking bench of the trigger sequencer, one task per scenario
// assumes the commander model and the bound checker
`timescale 1ns/10ps
module measurement_trigger_sequencer_tb_top;
  logic                  clk = 1'b0;          // 25 MHz clock
  logic                  rst_n = 1'b0;        // sync reset, low
  logic [2:0]            src_sel = 3'h0;      // trigger source
  logic [2:0]            ttl_sel = 3'h0;      // backplane line
  logic [15:0]           trig_count = 16'h0001;
  logic                  front_trig = 1'b0;   // front pin
  logic [7:0]            ttl_in = 8'h00;      // backplane lines
  logic                  meas_done = 1'b0;    // engine done
  logic                  dev_clear;           // from commander
  trig_seq_pkg::cmd_type cmd;                 // from commander
  logic                  meas_start, meas_store, result_rdy;
  logic                  bus_hold, cmd_ready, armed;
  logic [7:0]            ttl_out, ttl_oe;
  trig_seq_pkg::err_type err;
  int                    err_count = 0, tests_run = 0;
  int                    n_st = 0, n_res = 0, n_err = 0, n_sto = 0;
  logic [15:0]           last_err = 16'h0000;
  logic [15:0]           oe_seen = 16'h0000;  // ttl_out, ttl_oe seen
  always #20 clk = ~clk;
  commander_model cm (.clk, .cmd, .dev_clear);
  measurement_trigger_sequencer uut (.clk, .rst_n, .dev_clear, .cmd,
    .src_sel, .ttl_sel, .trig_count, .front_trig, .ttl_in, .meas_done,
    .meas_start, .meas_store, .result_rdy, .bus_hold, .cmd_ready, .err,
    .armed, .ttl_out, .ttl_oe);
  // ==========================================================
  // engine answers a cycle after each start; events are counted
  always @(posedge clk) begin
    meas_done <= (meas_start === 1'b1);
    if (meas_start === 1'b1) n_st <= n_st + 1;
    if (meas_start === 1'b1 && meas_store === 1'b1) n_sto <= n_sto + 1;
    if (result_rdy === 1'b1) n_res <= n_res + 1;
    if (err.valid === 1'b1) begin
      n_err <= n_err + 1;
      last_err <= err.code;
    end
    oe_seen <= oe_seen | {ttl_out, ttl_oe};
  end
  // ==========================================================
  // shared helpers
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // pin high past the sync latency, then low
  task automatic pulse(input logic front, input int ln);
    if (front) front_trig <= 1'b1;
    else ttl_in[ln] <= 1'b1;
    repeat (4) @(posedge clk);
    front_trig <= 1'b0;
    ttl_in <= 8'h00;
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_res(input int r);
    int k = 0;
    while (n_res == r && k < 300) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_errs();
    logic [2:0]  sr [3] = '{trig_seq_pkg::src_bus, trig_seq_pkg::src_bus,
                            trig_seq_pkg::src_hold};
    logic [2:0]  op [3] = '{trig_seq_pkg::cmd_trig_now,
                            trig_seq_pkg::cmd_query, trig_seq_pkg::cmd_query};
    logic [15:0] ec [3] = '{trig_seq_pkg::err_trigger_ignored,
      trig_seq_pkg::err_trig_deadlock, trig_seq_pkg::err_init_ignored};
    for (int i = 0; i < 3; i++) begin
      src_sel <= sr[i];
      cm.send(op[i]);
      repeat (3) @(posedge clk);
      chk(last_err === ec[i], "wrong error code");
    end
  endtask
  task automatic t_imm();
    int s = n_st;
    int o = n_sto;
    src_sel <= trig_seq_pkg::src_immediate_source;
    cm.send(trig_seq_pkg::cmd_init);
    repeat (4) @(posedge clk);
    chk(n_st == s + 1 && armed === 1'b0, "init reading");
    chk(n_sto == o + 1, "init reading not stored");
    cm.send(trig_seq_pkg::cmd_trig_now);
    repeat (3) @(posedge clk);
    chk(n_st == s + 1, "trigger now took a reading");
    chk(last_err === trig_seq_pkg::err_trigger_ignored, "no -211");
  endtask
  task automatic t_block();
    int s = n_st;
    int r = n_res;
    int o = n_sto;
    trig_count <= 16'h0003;
    cm.send(trig_seq_pkg::cmd_query);
    wait_res(r);
    chk(n_st == s + 3 && n_res == r + 1, "block of three");
    chk(n_sto == o, "query readings were stored");
  endtask
  task automatic t_ttl();
    int s = n_st;
    int r = n_res;
    int e = n_err;
    src_sel <= trig_seq_pkg::src_ttl;
    ttl_sel <= 3'h2;
    trig_count <= 16'h0002;
    // cleared off the edge so that the sampling process cannot race it
    @(negedge clk);
    oe_seen = 16'h0000;
    cm.send(trig_seq_pkg::cmd_query);
    cm.send(trig_seq_pkg::cmd_bus_trig);
    pulse(1'b1, 0);
    pulse(1'b0, 2);
    chk(bus_hold === 1'b1 && n_st == s + 1 && n_res == r, "held");
    chk(cmd_ready === 1'b0, "commands not refused");
    pulse(1'b0, 2);
    chk(n_res == r + 1 && bus_hold === 1'b0, "answer");
    chk(oe_seen === 16'h0404 && n_err == e, "line drive");
  endtask
  task automatic t_front();
    int s = n_st;
    src_sel <= trig_seq_pkg::src_front_connector_source;
    trig_count <= 16'h0001;
    cm.send(trig_seq_pkg::cmd_init);
    pulse(1'b1, 0);
    pulse(1'b0, 2);
    chk(armed === 1'b1 && n_st == s + 1, "front trigger");
    cm.send(trig_seq_pkg::cmd_abort);
    src_sel <= trig_seq_pkg::src_bus;
    cm.send(trig_seq_pkg::cmd_init);
    cm.send(trig_seq_pkg::cmd_bus_trig);
    repeat (3) @(posedge clk);
    chk(n_st == s + 2, "bus trigger");
    cm.send(trig_seq_pkg::cmd_abort);
  endtask
  task automatic t_clear();
    int r = n_res;
    src_sel <= trig_seq_pkg::src_front_connector_source;
    trig_count <= 16'h0002;
    cm.send(trig_seq_pkg::cmd_query);
    pulse(1'b1, 0);
    chk(bus_hold === 1'b1, "not held");
    cm.clear();
    repeat (3) @(posedge clk);
    chk(bus_hold === 1'b0 && n_res == r, "clear");
  endtask
  initial begin
    #(40 * 8000);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_errs();
    t_imm();
    t_block();
    t_ttl();
    t_front();
    t_clear();
    finish_test();
  end
endmodule

/* File: test/trig_seq_chk.sv */
// checker of the trigger sequencer, bound to its top module
// assumes one clock and the synchronous active-low reset
`timescale 1ns/10ps
module trig_seq_chk #(
  parameter int ttl_w = 8  // backplane line count
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  dev_clear,
  input wire trig_seq_pkg::cmd_type cmd,
  input wire logic [2:0]            src_sel,
  input wire logic [2:0]            ttl_sel,
  input wire logic                  meas_start,
  input wire logic                  meas_store,
  input wire logic                  result_rdy,
  input wire logic                  bus_hold,
  input wire logic                  cmd_ready,
  input wire trig_seq_pkg::err_type err,
  input wire logic                  armed,
  input wire logic [ttl_w-1:0]      ttl_oe
);
  // ==========================================================
  // decoded commands that the block takes
  wire logic tk  = cmd.valid & ~bus_hold;  // command taken
  wire logic trg = tk & (cmd.op == trig_seq_pkg::cmd_trig_now);
  wire logic qry = tk & (cmd.op == trig_seq_pkg::cmd_query);
  wire logic ini = tk & (cmd.op == trig_seq_pkg::cmd_init);
  wire logic gtr = tk & (cmd.op == trig_seq_pkg::cmd_bus_trig);
  wire logic immediate_source = src_sel == trig_seq_pkg::src_immediate_source;
  wire logic bsr = src_sel == trig_seq_pkg::src_bus;
  wire logic hsr = src_sel == trig_seq_pkg::src_hold;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // properties
  ready_inv_a: assert property (cmd_ready != bus_hold)
    else $error("cmd_ready not inverse of bus_hold");
  hold_wait_a: assert property (qry && !immediate_source && !bsr && !hsr |=>
    bus_hold)
    else $error("pulse query did not hold the bus");
  hold_end_a: assert property ($fell(bus_hold) |->
    $past(result_rdy) || $past(dev_clear) || !$past(rst_n))
    else $error("bus released without answer or clear");
  unarmed_a: assert property (trg && !armed |-> !meas_start ##1
    err.valid && err.code == trig_seq_pkg::err_trigger_ignored)
    else $error("unarmed trigger not refused");
  imm_init_a: assert property (ini && immediate_source |->
    meas_start && meas_store)
    else $error("immediate init took no stored reading");
  imm_trg_a: assert property (trg && immediate_source |=> err.valid &&
    err.code == trig_seq_pkg::err_trigger_ignored)
    else $error("immediate trigger not refused");
  deadlock_a: assert property (qry && bsr |=> err.valid &&
    err.code == trig_seq_pkg::err_trig_deadlock)
    else $error("bus source query gave no deadlock error");
  init_ign_a: assert property (qry && hsr |=> err.valid &&
    err.code == trig_seq_pkg::err_init_ignored)
    else $error("hold source query gave no init error");
  bus_trg_a: assert property (gtr && bsr && armed |-> meas_start)
    else $error("armed bus trigger took no reading");
  line_out_a: assert property (ttl_oe != '0 |->
    ttl_oe == (ttl_w'(1) << ttl_sel))
    else $error("completion drive off the chosen line");
  cover property (qry ##[1:300] result_rdy);
  cover property (bus_hold && dev_clear);
  cover property (err.valid);
endmodule
bind measurement_trigger_sequencer trig_seq_chk #(.ttl_w(ttl_w)) chk_i (
  .clk, .rst_n, .dev_clear, .cmd, .src_sel, .ttl_sel, .meas_start,
  .meas_store, .result_rdy, .bus_hold, .cmd_ready, .err, .armed, .ttl_oe);
